// ===== rtl/wrv_pkg.sv
// package for the reset supervisor, voltage detector and watchdog
// Notes on behaviour
// - supply flags update only while detect enable bit 0 is set
// - high supply flag bit 2 follows supply above upper threshold
// - low supply flag bit 1 follows supply below lower threshold
// - enabled detection with low flag raises interrupt request five
// - request five latches until software clear or reset
// - detect register bits 7..3 read ones, 2..1 read only, 0 writable
// - one-shot reset timer on rc clock holds reset until expiry
// - reset timer starts on power-up, watchdog timeout, stop recovery if delay
// - watchdog is retriggerable one-shot that resets cpu at terminal count
// - first refresh enables watchdog, later refreshes restart count
// - watchdog counts on internal rc clock tick
// - refresh instruction updates zero, sign and overflow flags
// - mode register writable only 60 cycles after first instruction
// - mode register is write only, reads return zero
// - mode bit 3 keeps watchdog counting during stop
// - mode bit 2 keeps watchdog counting during halt
// - timeout select bits 6..4 and 1..0 choose 5 ms to 5120 ms
// - upper select zero or two or more ones uses low bits only
// - timeout in stop resets, exits stop, keeps mode register
// - after watchdog reset the watchdog stays disabled until refresh
// - timeout outside stop returns mode register to defaults
// - power-on resets restore all defaults; watchdog resets keep the z, s, v flags and, on a stop timeout, the mode register; stop flag reads zero
package wrv_pkg;
   localparam logic [11:0] VDET_ADDR = 12'hD0C;
   localparam logic [11:0] WMODE_ADDR = 12'hF0F;
   localparam int VDET_EN_BIT = 0;
   localparam int VDET_LOW_BIT = 1;
   localparam int VDET_HIGH_BIT = 2;
   localparam logic [4:0] VDET_RSVD = 5'h1F;
   localparam logic [7:0] WMODE_RESET = 8'h0D;
   localparam int WM_STOP_BIT = 3;
   localparam int WM_HALT_BIT = 2;
   localparam logic [6:0] WINDOW_CYCLES = 7'h3C;
   // rc tick period in microseconds, timeouts counted in ticks of 1 ms
   localparam int RC_TICK_US = 1000;
   localparam int POR_TICKS = 16;
   localparam logic [12:0] TO_5MS = 13'h0005;
   localparam logic [12:0] TO_10MS = 13'h000A;
   localparam logic [12:0] TO_20MS = 13'h0014;
   localparam logic [12:0] TO_80MS = 13'h0050;
   localparam logic [12:0] TO_320MS = 13'h0140;
   localparam logic [12:0] TO_1280MS = 13'h0500;
   localparam logic [12:0] TO_5120MS = 13'h1400;
   typedef enum logic [1:0]
   {
      WD_IDLE = 2'b00,
      WD_RUN = 2'b01,
      WD_FIRE = 2'b10
   } wrv_wd_t;
endpackage

// ===== rtl/wrv_sync.sv
// two-flop synchroniser for one level
module wrv_sync
(
   input wire logic clk,
   input wire logic reset,
   input wire logic din,
   output logic dout
);
   logic meta_q;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// ===== rtl/wrv_supervisor.sv
// reset supervisor: voltage detect, power-on timer and watchdog
module wrv_supervisor
(
   input wire logic clk,
   input wire logic reset,
   input wire logic rcTick,
   input wire logic supplyHigh,
   input wire logic supplyLow,
   input wire logic stopRecovery,
   input wire logic stopDelayBit,
   input wire logic stopMode,
   input wire logic haltMode,
   input wire logic firstInstr,
   input wire logic cpuCycle,
   input wire logic watchdogRefresh,
   input wire logic irq5Clear,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [11:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic intRequestFive,
   output logic internalReset,
   output logic stopRecoveryFlag,
   output logic flagZero,
   output logic flagSign,
   output logic flagOverflow,
   output logic watchdogEnabled
);
   import wrv_pkg::*;

   logic highSync, lowSync, tickSync, tickSeen_q;
   logic [2:0] syncIn, syncOut;
   logic tickPulse;
   logic vdetEn_q, vHigh_q, vLow_q;
   logic [7:0] wmode_q;
   logic [6:0] winCnt_q;
   logic winOpen_q;
   logic [12:0] wdCnt_q, wdLimit;
   logic [4:0] porCnt_q;
   logic porBusy_q;
   logic wdTimeout;
   logic wdCountEn;
   wrv_wd_t wdState_q;

   // comparator outputs and the rc tick come from other timing domains
   assign syncIn = {rcTick, supplyLow, supplyHigh};
   for (genvar g = 0; g < 3; g++)
   begin : gSync
      wrv_sync u_wrv_sync (.clk(clk), .reset(reset), .din(syncIn[g]),
         .dout(syncOut[g]));
   end
   assign highSync = syncOut[0];
   assign lowSync = syncOut[1];
   assign tickSync = syncOut[2];

   always_ff @(posedge clk)
   begin
      if (reset)
         tickSeen_q <= 1'b0;
      else
         tickSeen_q <= tickSync;
   end
   assign tickPulse = tickSync & ~tickSeen_q;

   // voltage detect register
   always_ff @(posedge clk)
   begin
      if (reset || wdTimeout)
      begin
         vdetEn_q <= 1'b0;
         vHigh_q <= 1'b0;
         vLow_q <= 1'b0;
      end
      else
      begin
         if (regWrite && regAddr == VDET_ADDR)
            vdetEn_q <= regWdata[VDET_EN_BIT];
         if (vdetEn_q)
         begin
            vHigh_q <= highSync;
            vLow_q <= lowSync;
         end
      end
   end

   // request five sticky, new event wins over clear
   always_ff @(posedge clk)
   begin
      if (reset || wdTimeout)
         intRequestFive <= 1'b0;
      else if (vdetEn_q && vLow_q)
         intRequestFive <= 1'b1;
      else if (irq5Clear)
         intRequestFive <= 1'b0;
   end

   // register read data; mode register never reads back
   always_ff @(posedge clk)
   begin
      if (reset)
         regRdata <= 8'h00;
      else if (regRead && regAddr == VDET_ADDR)
         regRdata <= {VDET_RSVD, vHigh_q, vLow_q, vdetEn_q};
      else
         regRdata <= 8'h00;
   end

   // write window counter after first instruction
   always_ff @(posedge clk)
   begin
      if (reset || wdTimeout || stopRecovery)
      begin
         winCnt_q <= 7'h00;
         winOpen_q <= 1'b0;
      end
      else if (firstInstr && winCnt_q == 7'h00)
         winOpen_q <= 1'b1;
      else if (winOpen_q && cpuCycle)
      begin
         if (winCnt_q == WINDOW_CYCLES - 7'h01)
            winOpen_q <= 1'b0;
         winCnt_q <= winCnt_q + 7'h01;
      end
   end

   // mode register; stop timeout keeps it, other timeout restores it
   always_ff @(posedge clk)
   begin
      if (reset)
         wmode_q <= WMODE_RESET;
      else if (wdTimeout && !stopMode)
         wmode_q <= WMODE_RESET;
      else if (wdTimeout)
         wmode_q <= wmode_q;
      else if (regWrite && regAddr == WMODE_ADDR && winOpen_q)
         wmode_q <= regWdata;
   end

   // timeout tap select
   always_comb
   begin
      wdLimit = TO_5MS;
      case (wmode_q[6:4])
         3'b001: wdLimit = TO_320MS;
         3'b010: wdLimit = TO_1280MS;
         3'b100: wdLimit = TO_5120MS;
         default:
         begin
            case (wmode_q[1:0])
               2'b00: wdLimit = TO_5MS;
               2'b01: wdLimit = TO_10MS;
               2'b10: wdLimit = TO_20MS;
               default: wdLimit = TO_80MS;
            endcase
         end
      endcase
   end

   assign wdCountEn = tickPulse &&
      !(stopMode && !wmode_q[WM_STOP_BIT]) &&
      !(haltMode && !wmode_q[WM_HALT_BIT]);
   assign wdTimeout = (wdState_q == WD_FIRE);

   // watchdog state and counter
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wdState_q <= WD_IDLE;
         wdCnt_q <= 13'h0000;
      end
      else
      begin
         case (wdState_q)
            WD_IDLE:
            begin
               if (watchdogRefresh && !internalReset)
               begin
                  wdState_q <= WD_RUN;
                  wdCnt_q <= 13'h0000;
               end
            end
            WD_RUN:
            begin
               if (watchdogRefresh)
                  wdCnt_q <= 13'h0000;
               else if (wdCountEn)
               begin
                  if (wdCnt_q >= wdLimit - 13'h0001)
                     wdState_q <= WD_FIRE;
                  else
                     wdCnt_q <= wdCnt_q + 13'h0001;
               end
            end
            WD_FIRE:
            begin
               wdState_q <= WD_IDLE;
               wdCnt_q <= 13'h0000;
            end
            default:
               wdState_q <= WD_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         watchdogEnabled <= 1'b0;
      else
         watchdogEnabled <= (wdState_q == WD_RUN);
   end

   // power-on reset timer
   always_ff @(posedge clk)
   begin
      if (reset || wdTimeout || (stopRecovery && stopDelayBit))
      begin
         porBusy_q <= 1'b1;
         porCnt_q <= 5'h00;
      end
      else if (porBusy_q && tickPulse)
      begin
         if (porCnt_q == 5'(POR_TICKS - 1))
            porBusy_q <= 1'b0;
         else
            porCnt_q <= porCnt_q + 5'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         internalReset <= 1'b1;
      else
         internalReset <= porBusy_q;
   end

   always_ff @(posedge clk)
   begin
      if (reset || wdTimeout)
         stopRecoveryFlag <= 1'b0;
      else if (stopRecovery)
         stopRecoveryFlag <= 1'b1;
   end

   // refresh leaves z=1 s=0 v=0, the result of a zero compare
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         flagZero <= 1'b0;
         flagSign <= 1'b0;
         flagOverflow <= 1'b0;
      end
      else if (watchdogRefresh)
      begin
         flagZero <= 1'b1;
         flagSign <= 1'b0;
         flagOverflow <= 1'b0;
      end
   end

   property p_irq_sticky;
      @(posedge clk) disable iff (reset)
      (intRequestFive && !irq5Clear && !wdTimeout) |=> intRequestFive;
   endproperty
   a_irq_sticky: assert property (p_irq_sticky)
      else $error("request five dropped without clear");

   property p_irq_set;
      @(posedge clk) disable iff (reset)
      (vdetEn_q && vLow_q && !wdTimeout) |=> intRequestFive;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("low supply did not raise request five");

   property p_vdet_hold;
      @(posedge clk) disable iff (reset)
      (!vdetEn_q && !wdTimeout) |=> $stable(vLow_q) && $stable(vHigh_q);
   endproperty
   a_vdet_hold: assert property (p_vdet_hold)
      else $error("supply flags moved while detect disabled");

   property p_rsvd_ones;
      @(posedge clk) disable iff (reset)
      (regRead && regAddr == VDET_ADDR) |=> regRdata[7:3] == VDET_RSVD;
   endproperty
   a_rsvd_ones: assert property (p_rsvd_ones)
      else $error("reserved detect bits not ones");

   property p_wmode_noread;
      @(posedge clk) disable iff (reset)
      (regRead && regAddr == WMODE_ADDR) |=> regRdata == 8'h00;
   endproperty
   a_wmode_noread: assert property (p_wmode_noread)
      else $error("mode register read back");

   property p_locked;
      @(posedge clk) disable iff (reset)
      (!winOpen_q && !wdTimeout) |=> $stable(wmode_q);
   endproperty
   a_locked: assert property (p_locked)
      else $error("mode register changed while locked");

   property p_stop_keep;
      @(posedge clk) disable iff (reset)
      (wdTimeout && stopMode) |=> $stable(wmode_q);
   endproperty
   a_stop_keep: assert property (p_stop_keep)
      else $error("stop timeout changed mode register");

   property p_run_reset;
      @(posedge clk) disable iff (reset)
      (wdTimeout && !stopMode) |=> wmode_q == WMODE_RESET;
   endproperty
   a_run_reset: assert property (p_run_reset)
      else $error("timeout did not restore mode register");

   property p_disable_after;
      @(posedge clk) disable iff (reset)
      wdTimeout |=> wdState_q == WD_IDLE ##1 internalReset;
   endproperty
   a_disable_after: assert property (p_disable_after)
      else $error("watchdog not idle after timeout");

   property p_halt_freeze;
      @(posedge clk) disable iff (reset)
      (wdState_q == WD_RUN && haltMode && !wmode_q[WM_HALT_BIT]
         && !watchdogRefresh) |=> $stable(wdCnt_q);
   endproperty
   a_halt_freeze: assert property (p_halt_freeze)
      else $error("watchdog counted in halt while off");

   property p_stop_freeze;
      @(posedge clk) disable iff (reset)
      (wdState_q == WD_RUN && stopMode && !wmode_q[WM_STOP_BIT]
         && !watchdogRefresh) |=> $stable(wdCnt_q);
   endproperty
   a_stop_freeze: assert property (p_stop_freeze)
      else $error("watchdog counted in stop while off");

   property p_stop_delay;
      @(posedge clk) disable iff (reset)
      (stopRecovery && stopDelayBit) |=> porBusy_q ##1 internalReset;
   endproperty
   a_stop_delay: assert property (p_stop_delay)
      else $error("stop recovery did not start reset timer");

   property p_window_sat;
      @(posedge clk) disable iff (reset)
      (winCnt_q == WINDOW_CYCLES && !wdTimeout && !stopRecovery)
         |=> winCnt_q == WINDOW_CYCLES && !winOpen_q;
   endproperty
   a_window_sat: assert property (p_window_sat)
      else $error("write window reopened without reset");
endmodule

// ===== bench/wrv_cpu_model.sv
// processor core model issuing register accesses
module wrv_cpu_model
(
   input wire logic clk,
   input wire logic [7:0] regRdata,
   output logic regWrite,
   output logic regRead,
   output logic [11:0] regAddr,
   output logic [7:0] regWdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 12'h000;
      regWdata = 8'h00;
   end
   // one access; idle bus shows inverted values so stale data never matches
   task automatic access(input logic w, input logic [11:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      regWrite <= w;
      regRead <= !w;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
      #1;
      q = regRdata;
   endtask
endmodule

// ===== bench/wrv_supervisor_tb_top.sv
// self-checking bench for the reset supervisor
module wrv_supervisor_tb_top;
   import wrv_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset, rcTick, supplyHigh, supplyLow, stopRecovery;
   logic stopDelayBit, stopMode, haltMode, firstInstr, cpuCycle;
   logic watchdogRefresh, irq5Clear, regWrite, regRead;
   logic [11:0] regAddr;
   logic [7:0] regWdata, regRdata, q, eff;
   logic intRequestFive, internalReset, stopRecoveryFlag, irqExp;
   logic flagZero, flagSign, flagOverflow, watchdogEnabled;
   logic [1:0] rcDiv;
   logic [31:0] r;
   logic [9:0] tbl [12];
   int fail_count, compares, seed, n, t;
   wrv_supervisor u_wrv_supervisor (.clk(clk), .reset(reset),
      .rcTick(rcTick), .supplyHigh(supplyHigh), .supplyLow(supplyLow),
      .stopRecovery(stopRecovery), .stopDelayBit(stopDelayBit),
      .stopMode(stopMode), .haltMode(haltMode), .firstInstr(firstInstr),
      .cpuCycle(cpuCycle), .watchdogRefresh(watchdogRefresh),
      .irq5Clear(irq5Clear), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .intRequestFive(intRequestFive), .internalReset(internalReset),
      .stopRecoveryFlag(stopRecoveryFlag), .flagZero(flagZero),
      .flagSign(flagSign), .flagOverflow(flagOverflow),
      .watchdogEnabled(watchdogEnabled));
   wrv_cpu_model u_wrv_cpu_model (.clk(clk), .regRdata(regRdata),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWdata(regWdata));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // rc tick every 4 clocks keeps the long timeouts affordable
   always @(posedge clk)
   begin
      rcDiv <= rcDiv + 2'd1;
      rcTick <= rcDiv[1];
      cpuCycle <= ~cpuCycle;
   end
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      $display("mismatches %0d comparisons %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic clks(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic waitRst;
      n = 0;
      while (internalReset !== 1'b0 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic refresh;
      @(posedge clk);
      watchdogRefresh <= 1'b1;
      @(posedge clk);
      watchdogRefresh <= 1'b0;
      #1;
   endtask
   // first instruction, optional mode write, refresh; ends on an edge
   task automatic prime(input logic [7:0] m, input logic w);
      @(posedge clk);
      firstInstr <= 1'b1;
      @(posedge clk);
      firstInstr <= 1'b0;
      if (w)
         u_wrv_cpu_model.access(1'b1, WMODE_ADDR, m, q);
      refresh();
      @(posedge clk);
   endtask
   task automatic waitFire(input int lim);
      n = 0;
      while (internalReset !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   function automatic int ticks(input logic [7:0] m);
      case (m[6:4])
         3'b001: return 320;
         3'b010: return 1280;
         3'b100: return 5120;
         default: return m[1] ? (m[0] ? 80 : 20) : (m[0] ? 10 : 5);
      endcase
   endfunction
   initial
   begin
      #3000000;
      fail_count++;
      summarize();
   end
   initial
   begin
      {supplyHigh, supplyLow, stopRecovery, stopMode, haltMode} = 5'h00;
      {firstInstr, cpuCycle, watchdogRefresh, irq5Clear} = 4'h0;
      stopDelayBit = 1'b1;
      rcDiv = 2'd0;
      rcTick = 1'b0;
      reset = 1'b1;
      seed = 32'h0765;
      irqExp = 1'b0;
      fail_count = 0;
      compares = 0;
      // {late write, second refresh, mode code}; FF writes nothing
      tbl = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h010, 10'h020,
         10'h040, 10'h070, 10'h030, 10'h0FF, 10'h200, 10'h102};
      clks(8);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      chk("porHeld", 8'h01, internalReset);
      waitRst();
      t = POR_TICKS * 4;
      chk("porLen", 8'h01, n >= t - 8 && n <= t + 8);
      chk("porDone", 8'h00, internalReset);
      u_wrv_cpu_model.access(1'b0, VDET_ADDR, 8'h00, q);
      chk("vdetRst", 8'hF8, q);
      u_wrv_cpu_model.access(1'b1, VDET_ADDR, 8'hFF, q);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         r = (i == 0) ? 32'h2 : $random(seed);
         supplyHigh <= r[0] & ~r[1];
         supplyLow <= r[1];
         irqExp = irqExp | r[1];
         clks(6);
         u_wrv_cpu_model.access(1'b0, VDET_ADDR, 8'h00, q);
         chk("vdet", {5'h1F, r[0] & ~r[1], r[1], 1'b1}, q);
         chk("interrupt_request_five", irqExp, intRequestFive);
      end
      @(posedge clk);
      supplyLow <= 1'b0;
      clks(6);
      chk("irqHeld", 8'h01, intRequestFive);
      irq5Clear <= 1'b1;
      @(posedge clk);
      irq5Clear <= 1'b0;
      clks(2);
      chk("irqClr", 8'h00, intRequestFive);
      u_wrv_cpu_model.access(1'b0, WMODE_ADDR, 8'h00, q);
      chk("wmodeRd", 8'h00, q);
      for (int i = 0; i < 12; i++)
      begin
         @(posedge clk);
         firstInstr <= 1'b1;
         @(posedge clk);
         firstInstr <= 1'b0;
         // past 60 processor cycles the mode register must be locked
         if (tbl[i][9])
            clks(130);
         if (tbl[i][7:0] != 8'hFF)
            u_wrv_cpu_model.access(1'b1, WMODE_ADDR, tbl[i][7:0], q);
         eff = (tbl[i][7:0] == 8'hFF || tbl[i][9]) ? WMODE_RESET
            : tbl[i][7:0];
         refresh();
         // the enable output follows the state one clock later
         @(posedge clk);
         #1;
         chk("wdEn", 8'h01, watchdogEnabled);
         chk("flags", 8'h04, {flagZero, flagSign, flagOverflow});
         if (tbl[i][8])
         begin
            clks(40);
            refresh();
         end
         t = ticks(eff) * 4;
         n = 0;
         while (internalReset !== 1'b1 && n < 25000)
         begin
            @(posedge clk);
            n++;
         end
         chk("wdTime", 8'h01, n >= t - 4 && n <= t + 10);
         chk("wdTimeSrc", 8'h01, n >= t - 4);
         waitRst();
         chk("rstDone", 8'h00, internalReset);
         chk("wdOff", 8'h00, watchdogEnabled);
         chk("stopFlag", 8'h00, stopRecoveryFlag);
      end
      // stop recovery with the delay bit set starts the reset timer
      @(posedge clk);
      stopRecovery <= 1'b1;
      @(posedge clk);
      stopRecovery <= 1'b0;
      clks(2);
      chk("smrPor", 8'h01, internalReset);
      chk("smrFlag", 8'h01, stopRecoveryFlag);
      waitRst();
      chk("smrDone", 8'h00, internalReset);
      // fast recovery, as with an external clock needing no delay
      stopDelayBit <= 1'b0;
      stopRecovery <= 1'b1;
      @(posedge clk);
      stopRecovery <= 1'b0;
      clks(3);
      chk("smrFast", 8'h00, internalReset);
      stopDelayBit <= 1'b1;
      // halt freezes the count, stop with bit 3 set lets it run out
      prime(8'h08, 1'b1);
      haltMode <= 1'b1;
      clks(60);
      chk("haltFrz", 8'h00, internalReset);
      haltMode <= 1'b0;
      stopMode <= 1'b1;
      t = ticks(8'h08) * 4;
      waitFire(200);
      stopMode <= 1'b0;
      chk("stopRun", 8'h01, n >= t - 8 && n <= t + 10);
      waitRst();
      chk("stopWdOff", 8'h00, watchdogEnabled);
      chk("stopFlagClr", 8'h00, stopRecoveryFlag);
      // a timeout in stop keeps the mode, so no write is needed here
      prime(8'h00, 1'b0);
      waitFire(200);
      chk("stopKeep", 8'h01, n >= t - 4 && n <= t + 10);
      waitRst();
      // stop bit clear: no counting while stopped
      prime(8'h04, 1'b1);
      stopMode <= 1'b1;
      clks(60);
      chk("stopFrz", 8'h00, internalReset);
      stopMode <= 1'b0;
      t = ticks(8'h04) * 4;
      waitFire(200);
      chk("stopEnd", 8'h01, n >= t - 8 && n <= t + 10);
      waitRst();
      chk("stopEndRst", 8'h00, internalReset);
      summarize();
   end
endmodule
